// [logic/gauge_pkg.sv]
// Shared constants, strap codes, register offsets and lookup functions of the gauge front end
`default_nettype none
package gauge_pkg;

  // Clock rate
  localparam longint CLK_HZ = 40_000_000;

  // Strap settling time before the one-shot sample, in ns
  localparam longint SETTLE_NS = 10_000;
  // Least time, so rounded up
  localparam int SETTLE_CYC = int'((SETTLE_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  // Discharge quantum of one converter pulse, 3.125 uVh held in nVh
  localparam longint QUANTUM_NVH = 3125;
  // Minimum discharge threshold in uV
  localparam longint MIN_SENSE_UV = 250;
  // Longest pulse spacing still at or above the threshold, rounded down
  localparam longint FILTER_CYC_L = (QUANTUM_NVH * 3600 * CLK_HZ) / (MIN_SENSE_UV * 1000);
  localparam int FILTER_CYC = int'(FILTER_CYC_L);

  // Three-level strap codes
  localparam logic [1:0] CODE_LOW = 2'h0;
  localparam logic [1:0] CODE_FLOAT = 2'h1;
  localparam logic [1:0] CODE_HIGH = 2'h2;

  // Strap count and segment count
  localparam int NUM_STRAPS = 6;
  localparam int NUM_SEGS = 5;

  // Register offsets on the host register port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS1 = 8'h01;
  localparam logic [7:0] REG_FULL_CNT = 8'h10;
  localparam logic [7:0] REG_FNAC = 8'h11;
  localparam logic [7:0] REG_DCR = 8'h2e;

  // Field positions
  localparam int CTRL_AUX_BIT = 0;
  localparam int FLAGS_INIT_BIT = 0;
  localparam int FLAGS_AUX_BIT = 6;

  // Reset values
  localparam logic [15:0] DCR_RESET = 16'h0000;
  localparam logic [15:0] ZERO_CAP = 16'h0000;

  // Full count selected by the first two straps
  function automatic logic [15:0] full_count(input logic [1:0] c1, input logic [1:0] c2);
    case ({c1, c2})
      {CODE_HIGH, CODE_HIGH}: full_count = 16'hbc00;
      {CODE_HIGH, CODE_FLOAT}: full_count = 16'hb400;
      {CODE_HIGH, CODE_LOW}: full_count = 16'ha900;
      {CODE_FLOAT, CODE_HIGH}: full_count = 16'h9c00;
      {CODE_FLOAT, CODE_FLOAT}: full_count = 16'h9600;
      {CODE_FLOAT, CODE_LOW}: full_count = 16'h8d00;
      {CODE_LOW, CODE_HIGH}: full_count = 16'h7c00;
      {CODE_LOW, CODE_FLOAT}: full_count = 16'h7100;
      default: full_count = 16'h6600;
    endcase
  endfunction

  // Number of display segments chosen by the display-mode strap
  function automatic logic [2:0] seg_count(input logic [1:0] c);
    case (c)
      CODE_HIGH: seg_count = 3'h5;
      CODE_FLOAT: seg_count = 3'h4;
      default: seg_count = 3'h2;
    endcase
  endfunction

endpackage
`default_nettype wire

// [logic/strap_sampler.sv]
// One-shot sampler and decoder of the three-level configuration straps
`timescale 1ns/1ps
`default_nettype none
module strap_sampler #(
  parameter int SETTLE = gauge_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin comparators: above upper level, below lower level
  input wire logic [gauge_pkg::NUM_STRAPS-1:0] strap_above,
  input wire logic [gauge_pkg::NUM_STRAPS-1:0] strap_below,
  // Latched codes and completion
  output logic [2*gauge_pkg::NUM_STRAPS-1:0] codes,
  output logic done
);

  // Sampler states
  typedef enum logic [1:0] {S_SETTLE, S_SAMPLE, S_DONE} samp_state_t;

  samp_state_t state_r, state_nxt;
  logic [15:0] cnt_r; // Settle counter
  logic [2*gauge_pkg::NUM_STRAPS-1:0] codes_r; // Latched codes
  logic [2*gauge_pkg::NUM_STRAPS-1:0] dec_w; // Live decode

  // Pin levels to two-bit code
  function automatic logic [1:0] decode(input logic above, input logic below);
    if (above) begin
      decode = gauge_pkg::CODE_HIGH;
    end else if (below) begin
      decode = gauge_pkg::CODE_LOW;
    end else begin
      decode = gauge_pkg::CODE_FLOAT;
    end
  endfunction

  // Decode every strap
  genvar gi;
  generate
    for (gi = 0; gi < gauge_pkg::NUM_STRAPS; gi++) begin : g_dec
      assign dec_w[2*gi +: 2] = decode(strap_above[gi], strap_below[gi]);
    end
  endgenerate

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_SETTLE: if (cnt_r == 16'(SETTLE - 1)) state_nxt = S_SAMPLE;
      S_SAMPLE: state_nxt = S_DONE;
      S_DONE: state_nxt = S_DONE;
      default: state_nxt = S_SETTLE;
    endcase
  end

  // Settle, then sample exactly once
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_SETTLE;
      cnt_r <= 16'h0000;
      codes_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == S_SETTLE) cnt_r <= cnt_r + 16'h0001;
      if (state_r == S_SAMPLE) codes_r <= dec_w;
    end
  end

  assign codes = codes_r;
  assign done = (state_r == S_DONE);

  // Codes never change once sampled
  property p_codes_hold;
    @(posedge clk) disable iff (rst) done |=> $stable(codes_r);
  endproperty
  a_codes_hold: assert property (p_codes_hold) else $error("strap codes moved");

  // Sampling is not done in the first three cycles after reset
  property p_done_time;
    @(posedge clk) $fell(rst) |-> !done [*3];
  endproperty
  a_done_time: assert property (p_done_time) else $error("sampling ended early");

endmodule
`default_nettype wire

// [logic/discharge_filter.sv]
// Magnitude filter that passes converter pulses only at or above the minimum rate
`timescale 1ns/1ps
`default_nettype none
module discharge_filter #(
  parameter int MAX_GAP = gauge_pkg::FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter pulse and its polarity
  input wire logic conv_pulse,
  input wire logic conv_positive,
  input wire logic enable,
  // One-cycle pulse per counted quantum
  output logic count_pulse
);

  logic [31:0] gap_r; // Cycles since last positive pulse, saturating
  logic armed_r; // Last pulse seen was positive
  logic cnt_r; // Registered count pulse
  logic take_w; // Positive pulse seen
  logic in_rate_w; // Spacing within the threshold rate
  logic sat_w; // Gap counter beyond limit

  assign take_w = enable && conv_pulse && conv_positive;
  assign sat_w = (gap_r > 32'(MAX_GAP));
  assign in_rate_w = armed_r && !sat_w;

  // Measure pulse spacing; count only a quick enough pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r <= 32'h0000_0000;
      armed_r <= 1'b0;
      cnt_r <= 1'b0;
    end else begin
      cnt_r <= take_w && in_rate_w;
      if (take_w) begin
        gap_r <= 32'h0000_0001;
        armed_r <= 1'b1;
      end else if (enable && conv_pulse) begin
        // Negative sense is not discharge
        armed_r <= 1'b0;
      end else if (!sat_w) begin
        gap_r <= gap_r + 32'h0000_0001;
      end
    end
  end

  assign count_pulse = cnt_r;

  // A count follows only a positive pulse in rate
  property p_count_cause;
    @(posedge clk) disable iff (rst) count_pulse |-> $past(take_w) && $past(in_rate_w);
  endproperty
  a_count_cause: assert property (p_count_cause) else $error("count without cause");

  // A slow pulse is never counted
  property p_slow_blocked;
    @(posedge clk) disable iff (rst) (take_w && sat_w) |=> !count_pulse;
  endproperty
  a_slow_blocked: assert property (p_slow_blocked) else $error("slow pulse counted");

endmodule
`default_nettype wire

// [logic/gauge_front_end.sv]
// Digital front end of the primary-cell capacity monitor
`timescale 1ns/1ps
`default_nettype none
module gauge_front_end #(
  parameter int FILTER_GAP = gauge_pkg::FILTER_CYC,
  parameter int SETTLE = gauge_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap comparators on the shared pins
  input wire logic [gauge_pkg::NUM_STRAPS-1:0] strap_above,
  input wire logic [gauge_pkg::NUM_STRAPS-1:0] strap_below,
  // Display push-button, active low
  input wire logic display_enable_n,
  // Converter pulses
  input wire logic conv_pulse,
  input wire logic conv_positive,
  // Host register port from the link decoder
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  // Common LED source pin
  output logic led_common_source_o,
  output logic led_common_source_oe_n,
  // Segment pins
  output logic [gauge_pkg::NUM_SEGS-1:0] led_segment_out_o,
  output logic [gauge_pkg::NUM_SEGS-1:0] led_segment_out_oe_n,
  // Open-drain auxiliary pin
  output logic aux_drain_output_o,
  output logic aux_drain_output_oe_n,
  // Latched configuration
  output logic [1:0] scale_code,
  output logic [1:0] comp_code,
  output logic init_done
);

  // Sampler and filter results
  logic [2*gauge_pkg::NUM_STRAPS-1:0] codes_w; // All strap codes
  logic done_w; // Sampling complete
  logic count_w; // Filtered discharge quantum

  // Gauge registers
  logic [15:0] full_cnt_r; // Programmed full count
  logic [15:0] fnac_r; // Full reference capacity
  logic [15:0] dcr_r; // Discharge count
  logic aux_r; // Host request to pull aux pin low
  logic done_d_r; // Sampling complete, delayed
  logic [2:0] nseg_r; // Segments in use

  // Output flops
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic src_oe_n_r;
  logic [gauge_pkg::NUM_SEGS-1:0] seg_oe_n_r;
  logic aux_oe_n_r;
  logic [1:0] scale_r;
  logic [1:0] comp_r;

  // Strap sampler
  strap_sampler #(
    .SETTLE(SETTLE)
  ) u_straps (
    .clk(clk),
    .rst(rst),
    .strap_above(strap_above),
    .strap_below(strap_below),
    .codes(codes_w),
    .done(done_w)
  );

  // Magnitude filter, active once configured
  discharge_filter #(
    .MAX_GAP(FILTER_GAP)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .conv_pulse(conv_pulse),
    .conv_positive(conv_positive),
    .enable(done_w),
    .count_pulse(count_w)
  );

  // Strap fields
  wire [1:0] c1_w = codes_w[1:0];
  wire [1:0] c2_w = codes_w[3:2];
  wire [1:0] c3_w = codes_w[5:4];
  wire [1:0] c4_w = codes_w[7:6];
  wire [1:0] c5_w = codes_w[9:8];
  wire [1:0] c6_w = codes_w[11:10];

  // First cycle after sampling ends
  wire load_w = done_w && !done_d_r;
  // Full count looked up from the first two straps
  wire [15:0] full_sel_w = gauge_pkg::full_count(c1_w, c2_w);
  // Initial capacity from the sixth strap
  wire [15:0] fnac_init_w = (c6_w == gauge_pkg::CODE_HIGH) ? full_sel_w : gauge_pkg::ZERO_CAP;

  // Host write decodes
  wire wr_ctrl_w = host_wr && (host_addr == gauge_pkg::REG_CTRL);
  wire wr_fnac_w = host_wr && (host_addr == gauge_pkg::REG_FNAC);
  wire wr_dcr_w = host_wr && (host_addr == gauge_pkg::REG_DCR);

  // Latch configuration once sampling finishes
  always_ff @(posedge clk) begin
    if (rst) begin
      done_d_r <= 1'b0;
      full_cnt_r <= gauge_pkg::ZERO_CAP;
      nseg_r <= 3'h0;
      scale_r <= gauge_pkg::CODE_LOW;
      comp_r <= gauge_pkg::CODE_LOW;
    end else begin
      done_d_r <= done_w;
      if (load_w) begin
        full_cnt_r <= full_sel_w;
        scale_r <= c3_w;
        comp_r <= c4_w;
        nseg_r <= gauge_pkg::seg_count(c5_w);
      end
    end
  end

  // Full reference: strap-chosen at init, host may overwrite
  always_ff @(posedge clk) begin
    if (rst) begin
      fnac_r <= gauge_pkg::ZERO_CAP;
    end else if (load_w) begin
      fnac_r <= fnac_init_w;
    end else if (wr_fnac_w) begin
      fnac_r <= host_wdata;
    end
  end

  // Discharge counter; a host write takes the place of a count
  always_ff @(posedge clk) begin
    if (rst) begin
      dcr_r <= gauge_pkg::DCR_RESET;
    end else if (load_w) begin
      dcr_r <= gauge_pkg::DCR_RESET;
    end else if (wr_dcr_w) begin
      dcr_r <= host_wdata;
    end else if (count_w && dcr_r != 16'hffff) begin
      dcr_r <= dcr_r + 16'h0001;
    end
  end

  // Auxiliary pin request from host commands
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_r <= 1'b0;
    end else if (wr_ctrl_w) begin
      aux_r <= host_wdata[gauge_pkg::CTRL_AUX_BIT];
    end
  end

  // Remaining capacity, floored at zero
  wire [15:0] avail_w = (fnac_r > dcr_r) ? (fnac_r - dcr_r) : 16'h0000;
  // Capacity times segment count, compared with full count steps
  wire [18:0] avail_x_w = 19'(avail_w) * 19'(nseg_r);

  // Segment lighting decision per segment
  logic [gauge_pkg::NUM_SEGS-1:0] lit_w;
  genvar gs;
  generate
    for (gs = 0; gs < gauge_pkg::NUM_SEGS; gs++) begin : g_seg
      wire [18:0] step_w = 19'(full_cnt_r) * 19'(gs);
      assign lit_w[gs] = (3'(gs) < nseg_r) && (avail_x_w > step_w);
    end
  endgenerate

  // Display is on only while the button holds the input low
  wire show_w = done_d_r && !display_enable_n;

  // Pin drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      src_oe_n_r <= 1'b1;
      seg_oe_n_r <= '1;
      aux_oe_n_r <= 1'b1;
    end else begin
      src_oe_n_r <= !show_w;
      seg_oe_n_r <= show_w ? ~lit_w : '1;
      aux_oe_n_r <= !aux_r;
    end
  end

  // Flags register view
  logic [15:0] flags_w;
  always_comb begin
    flags_w = 16'h0000;
    flags_w[gauge_pkg::FLAGS_INIT_BIT] = done_d_r;
    flags_w[gauge_pkg::FLAGS_AUX_BIT] = !aux_oe_n_r;
  end

  // Read multiplexer; unmapped offsets read zero
  logic [15:0] rmux_w;
  always_comb begin
    case (host_addr)
      gauge_pkg::REG_CTRL: rmux_w = {15'h0000, aux_r};
      gauge_pkg::REG_FLAGS1: rmux_w = flags_w;
      gauge_pkg::REG_FULL_CNT: rmux_w = full_cnt_r;
      gauge_pkg::REG_FNAC: rmux_w = fnac_r;
      gauge_pkg::REG_DCR: rmux_w = dcr_r;
      default: rmux_w = 16'h0000;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_rd;
      if (host_rd) rdata_r <= rmux_w;
    end
  end

  // Outputs
  assign host_rdata = rdata_r;
  assign host_rvalid = rvalid_r;
  assign led_common_source_o = 1'b1;
  assign led_common_source_oe_n = src_oe_n_r;
  assign led_segment_out_o = '0;
  assign led_segment_out_oe_n = seg_oe_n_r;
  assign aux_drain_output_o = 1'b0;
  assign aux_drain_output_oe_n = aux_oe_n_r;
  assign scale_code = scale_r;
  assign comp_code = comp_r;
  assign init_done = done_d_r;

  // Common source stays off until sampling is over
  property p_src_init;
    @(posedge clk) disable iff (rst) !done_w |=> led_common_source_oe_n [*2];
  endproperty
  a_src_init: assert property (p_src_init) else $error("source on during init");

  // Source on only a cycle after the button is held low
  property p_src_idle;
    @(posedge clk) disable iff (rst)
      !led_common_source_oe_n |-> $past(!display_enable_n) && $past(done_d_r);
  endproperty
  a_src_idle: assert property (p_src_idle) else $error("source on while off");

  // Any sinking segment implies the source is on
  property p_seg_sink;
    @(posedge clk) disable iff (rst) (led_segment_out_oe_n != '1) |-> !led_common_source_oe_n;
  endproperty
  a_seg_sink: assert property (p_seg_sink) else $error("segment without source");

  // Released input turns the display off next cycle
  property p_dark_off;
    @(posedge clk) disable iff (rst)
      display_enable_n |=> led_common_source_oe_n && (led_segment_out_oe_n == '1);
  endproperty
  a_dark_off: assert property (p_dark_off) else $error("display on when disabled");

  // Load of configuration sets capacity by the sixth strap
  property p_init_cap;
    @(posedge clk) disable iff (rst)
      load_w |=> (dcr_r == 16'h0000) && (fnac_r == $past(fnac_init_w))
        && (full_cnt_r == $past(full_sel_w));
  endproperty
  a_init_cap: assert property (p_init_cap) else $error("bad initial capacity");

  // Aux pin follows the written control bit two cycles after the write
  property p_aux_mirror;
    @(posedge clk) disable iff (rst)
      wr_ctrl_w |=> ##1 (aux_drain_output_oe_n == !$past(host_wdata[0], 2));
  endproperty
  a_aux_mirror: assert property (p_aux_mirror) else $error("aux pin not as commanded");

  // In two-segment mode, segments 2 to 4 never light
  property p_mode_segs;
    @(posedge clk) disable iff (rst)
      (nseg_r == 3'h2) |-> led_segment_out_oe_n[4:2] == 3'h7;
  endproperty
  a_mode_segs: assert property (p_mode_segs) else $error("segment outside mode lit");

  // A filtered quantum advances the counter by one
  property p_dcr_step;
    @(posedge clk) disable iff (rst)
      (count_w && !wr_dcr_w && !load_w && dcr_r != 16'hffff) |=> dcr_r == $past(dcr_r) + 16'h0001;
  endproperty
  a_dcr_step: assert property (p_dcr_step) else $error("discharge count missed");

  // Segments stay released before sampling completes
  property p_seg_init;
    @(posedge clk) disable iff (rst) !done_d_r |=> led_segment_out_oe_n == '1;
  endproperty
  a_seg_init: assert property (p_seg_init) else $error("segment driven in init");

  // Main scenarios
  c_display_on: cover property (@(posedge clk) disable iff (rst) !led_common_source_oe_n);
  c_count: cover property (@(posedge clk) disable iff (rst) count_w);
  c_aux_low: cover property (@(posedge clk) disable iff (rst) !aux_drain_output_oe_n);
  c_read: cover property (@(posedge clk) disable iff (rst) host_rvalid);

endmodule
`default_nettype wire

// [sim/host_model.sv]
// Behavioural host controller that issues register reads and writes to the gauge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Requests to the gauge
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_addr,
  output logic [15:0] host_wdata,
  // Answer from the gauge
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid
);
  // Idle bus at time zero
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 16'h0000;
  end

  // Write: strobe held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 1'b0;
    // Released lines must not keep looking valid
    host_addr = ~a;
    host_wdata = ~d;
  endtask

  // Read: answer taken one cycle after the strobe, unknown if no valid pulse
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk);
    host_rd = 1'b0;
    host_addr = ~a;
    d = (host_rvalid === 1'b1) ? host_rdata : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// [sim/gauge_front_end_tb.sv]
// Self-checking bench of the gauge front end
`timescale 1ns/1ps
`default_nettype none
module gauge_front_end_tb;
  // Stimulus driven by the bench
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] strap_above = 6'h33;
  logic [5:0] strap_below = 6'h08;
  logic display_enable_n = 1'b0;
  logic conv_pulse = 1'b0;
  logic conv_positive = 1'b0;
  // Host port
  logic host_wr;
  logic host_rd;
  logic [7:0] host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic host_rvalid;
  // Pins and status from the design
  logic src_o;
  logic src_oe_n;
  logic [4:0] seg_o;
  logic [4:0] seg_oe_n;
  logic aux_o;
  logic aux_oe_n;
  logic [1:0] scale_code;
  logic [1:0] comp_code;
  logic init_done;
  // Counters and scratch
  int err_total = 0;
  int num_checks = 0;
  logic [15:0] rv;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Short counts so the run stays brief
  gauge_front_end #(.FILTER_GAP(20), .SETTLE(4)) uut (
    .clk(clk), .rst(rst), .strap_above(strap_above), .strap_below(strap_below),
    .display_enable_n(display_enable_n), .conv_pulse(conv_pulse), .conv_positive(conv_positive),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .led_common_source_o(src_o), .led_common_source_oe_n(src_oe_n),
    .led_segment_out_o(seg_o), .led_segment_out_oe_n(seg_oe_n),
    .aux_drain_output_o(aux_o), .aux_drain_output_oe_n(aux_oe_n),
    .scale_code(scale_code), .comp_code(comp_code), .init_done(init_done)
  );

  // Host controller model
  host_model host (
    .clk(clk), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid)
  );

  // Single comparison, four-state exact
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Report and end the run
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset with given straps, button held to prove the display stays dark until init
  task automatic do_reset(input logic [5:0] above, input logic [5:0] below);
    int n;
    @(negedge clk);
    rst = 1'b1;
    display_enable_n = 1'b0;
    strap_above = above;
    strap_below = below;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 60) begin
      chk("src_oe_n init", 16'h0001, {15'h0, src_oe_n});
      chk("seg_oe_n init", 16'h001f, {11'h0, seg_oe_n});
      @(negedge clk);
      n++;
    end
    chk("init_done", 16'h0001, {15'h0, init_done});
    display_enable_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  // Hold the button two cycles, check lit pattern, release and check dark
  task automatic press(input logic [4:0] exp_seg);
    @(negedge clk);
    display_enable_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("src_oe_n on", 16'h0000, {15'h0, src_oe_n});
    chk("src_o", 16'h0001, {15'h0, src_o});
    chk("seg_oe_n on", {11'h0, exp_seg}, {11'h0, seg_oe_n});
    chk("seg_o", 16'h0000, {11'h0, seg_o});
    display_enable_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("src_oe_n off", 16'h0001, {15'h0, src_oe_n});
    chk("seg_oe_n off", 16'h001f, {11'h0, seg_oe_n});
  endtask

  // One converter pulse, next one gap cycles later
  task automatic pulse(input logic pos, input int gap);
    @(negedge clk);
    conv_pulse = 1'b1;
    conv_positive = pos;
    @(negedge clk);
    conv_pulse = 1'b0;
    repeat (gap - 2) @(negedge clk);
  endtask

  // Main sequence
  initial begin
    // Straps 1,2 high, 3 float, 4 low, 5 high, 6 high
    do_reset(6'h33, 6'h08);
    chk("scale_code", 16'h0001, {14'h0, scale_code});
    chk("comp_code", 16'h0000, {14'h0, comp_code});
    host.rd(gauge_pkg::REG_FULL_CNT, rv);
    chk("full count", 16'hbc00, rv);
    host.rd(gauge_pkg::REG_FNAC, rv);
    chk("fnac full", 16'hbc00, rv);
    host.rd(gauge_pkg::REG_DCR, rv);
    chk("dcr reset", 16'h0000, rv);
    press(5'h00);
    // Arm, count, disarm, arm, count, stale gap, count
    pulse(1'b1, 5);
    pulse(1'b1, 5);
    pulse(1'b0, 5);
    pulse(1'b1, 5);
    pulse(1'b1, 30);
    pulse(1'b1, 5);
    pulse(1'b1, 5);
    repeat (4) @(negedge clk);
    host.rd(gauge_pkg::REG_DCR, rv);
    chk("dcr counts", 16'h0003, rv);
    // Host overwrites discharge count; two of five segments remain
    host.wr(gauge_pkg::REG_DCR, 16'h9600);
    host.rd(gauge_pkg::REG_DCR, rv);
    chk("dcr written", 16'h9600, rv);
    press(5'h1c);
    // Read-only and unmapped places
    host.wr(gauge_pkg::REG_FULL_CNT, 16'h1234);
    host.rd(gauge_pkg::REG_FULL_CNT, rv);
    chk("full count ro", 16'hbc00, rv);
    host.rd(8'h7f, rv);
    chk("unmapped", 16'h0000, rv);
    // Auxiliary drain output and its flag
    host.wr(gauge_pkg::REG_CTRL, 16'h0001);
    repeat (2) @(negedge clk);
    chk("aux_oe_n on", 16'h0000, {15'h0, aux_oe_n});
    chk("aux_o", 16'h0000, {15'h0, aux_o});
    host.rd(gauge_pkg::REG_FLAGS1, rv);
    chk("flags on", 16'h0041, rv & 16'h0041);
    host.wr(gauge_pkg::REG_CTRL, 16'h0000);
    repeat (2) @(negedge clk);
    chk("aux_oe_n off", 16'h0001, {15'h0, aux_oe_n});
    host.rd(gauge_pkg::REG_FLAGS1, rv);
    chk("flags off", 16'h0001, rv & 16'h0041);
    // Straps 1,2 high, 3 float, 4 low, 5 float, 6 low: four segments, capacity zero
    do_reset(6'h03, 6'h28);
    host.rd(gauge_pkg::REG_FNAC, rv);
    chk("fnac zero", 16'h0000, rv);
    press(5'h1f);
    host.wr(gauge_pkg::REG_FNAC, 16'hbc00);
    press(5'h10);
    // Straps 1 low, 2 float, 3 high, 4 float, 5 low, 6 high: two segments
    do_reset(6'h24, 6'h11);
    chk("scale_code high", 16'h0002, {14'h0, scale_code});
    chk("comp_code float", 16'h0001, {14'h0, comp_code});
    host.rd(gauge_pkg::REG_FULL_CNT, rv);
    chk("full count lz", 16'h7100, rv);
    press(5'h1c);
    // Exactly half left is not above the second step
    host.wr(gauge_pkg::REG_DCR, 16'h3880);
    press(5'h1e);
    give_verdict();
  end

  // Watchdog against a hang
  initial begin
    #(25 * 5000);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end
endmodule
`default_nettype wire
